// ===== core/pdc_defs.svh
// register offsets, field positions, reset values and cycle counts of the dma channel
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH
`define PDC_OFS_CPTR0 8'h00
`define PDC_OFS_APTR0 8'h04
`define PDC_OFS_CTRL 8'h08
`define PDC_OFS_CPTR1 8'h0C
`define PDC_OFS_APTR1 8'h10
`define PDC_OFS_SWAP 8'h14
`define PDC_CTL_PEND 5
`define PDC_CTL_MASK 4
`define PDC_CTL_IMSK 3
`define PDC_SWP_EN 0
`define PDC_RST_BYTE 8'h00
`define PDC_RST_PRIO 3'h7
`define PDC_SAMPLE_LAST 3'h4
`define PDC_RF_LAST 5'h07
`define PDC_MEM_LAST 5'h0F
`define PDC_RF_RDA 5'h00
`define PDC_RF_RDC 5'h01
`define PDC_RF_MOVE 5'h02
`define PDC_RF_WRA 5'h03
`define PDC_RF_WRC 5'h04
`define PDC_M_RDCH 5'h00
`define PDC_M_RDCL 5'h01
`define PDC_M_RDAH 5'h02
`define PDC_M_RDAL 5'h03
`define PDC_M_MOVE 5'h04
`define PDC_M_WRAH 5'h05
`define PDC_M_WRAL 5'h06
`define PDC_M_WRCH 5'h07
`define PDC_M_WRCL 5'h08
`endif

// ===== core/pdc_pkg.sv
// types shared by the peripheral dma channel
package pdc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} pdc_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } pdc_rf_req_t;
  typedef struct packed {
    logic req;
    logic we;
    logic seg_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pdc_mem_req_t;
  typedef struct packed {
    logic [2:0] current_priority_level;
    logic top_isr;
    logic instr_end;
    logic irq_ack;
  } pdc_core_in_t;
endpackage : pdc_pkg

// ===== core/pdc_channel.sv
// peripheral dma channel with ahb-lite control registers
// Contract
// [R1] blocks up to 222 rf, 65536 memory
// [R2] rf mode: address even, count odd register
// [R3] counter pointer bit 0 selects rf/memory
// [R4] memory mode: 16-bit address and count pairs
// [R5] address pointer bit 0 selects segment register
// [R6] move datum, increment address, decrement count
// [R7] software keeps descriptors in 00h..DFh
// [R8] software preloads count and start address
// [R9] direction set by peripheral mode
// [R10] request when pending and mask set
// [R11] arbitrated with interrupts, eight levels
// [R12] dma needs level >= cpl, irq strictly higher
// [R13] same level: transfer before interrupt
// [R14] cpl unchanged, transfer not interruptible
// [R15] count zero: clear mask, end-of-block irq
// [R16] no acknowledge during top-level service
// [R17] requests sampled every 5 clock cycles
// [R18] rf transfer takes 8 cycles
// [R19] memory transfer 16 cycles plus waits
// [R20] swap mode alternates two descriptor tables
// [R21] swap block end keeps mask, raises irq
// [R22] pending set by trigger, cleared on ack
// [R23] irq mask enables end-of-block irq
// [R24] priority 0 highest through 7 lowest
// [R25] table-select flag toggles each block end; the code toggles it only while swap mode is enabled
`include "pdc_defs.svh"
module pdc_channel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pdc_pkg::pdc_core_in_t core_in,
  output logic dma_busy,
  output logic irq_req,
  output logic [2:0] irq_level,
  input wire logic trigger,
  input wire logic periph_to_core,
  input wire logic [7:0] periph_rdata,
  output logic [7:0] periph_wdata,
  output logic periph_wr,
  output logic periph_rd,
  output pdc_pkg::pdc_rf_req_t rf_req,
  input wire logic [7:0] rf_rdata,
  output pdc_pkg::pdc_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready
);
  import pdc_pkg::*;

  // bus side state
  logic bw_r, bw_nxt;
  logic [7:0] wa_r, wa_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic ap_valid;

  // channel state
  pdc_state_t state_r, state_nxt;
  logic pend_r, pend_nxt;
  logic mask_r, mask_nxt;
  logic imsk_r, imsk_nxt;
  logic [2:0] prio_r, prio_nxt;
  logic [1:0][7:0] cptr_r, cptr_nxt;
  logic [1:0][7:0] aptr_r, aptr_nxt;
  logic swap_en_r, swap_en_nxt;
  logic tsel_r, tsel_nxt;
  logic eob_r, eob_nxt;
  logic irq_req_r, irq_req_nxt;
  logic [2:0] samp_r, samp_nxt;
  logic [4:0] step_r, step_nxt;
  logic rfm_r, rfm_nxt;
  logic [7:0] dcp_r, dcp_nxt;
  logic [7:0] dap_r, dap_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] adr_r, adr_nxt;
  logic [7:0] pwd_r, pwd_nxt;
  logic pwr_r, pwr_nxt;
  logic prd_r, prd_nxt;

  logic tick, dma_ok, irq_ok, irq_cond, last_step, zero, block_end, stall;
  logic [15:0] adr_inc, cnt_dec;
  logic [7:0] cpe, cpo, ape, apo, wd;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign dma_busy = (state_r == ST_RUN);
  assign irq_req = irq_req_r;
  assign irq_level = prio_r;
  assign periph_wdata = pwd_r;
  assign periph_wr = pwr_r;
  assign periph_rd = prd_r;

  assign ap_valid = hsel & htrans[1] & hready;
  assign wd = hwdata[7:0];

  // bus: zero-wait slave, read data registered from the address phase
  always_comb begin
    bw_nxt = ap_valid & hwrite;
    wa_nxt = haddr[7:0];
    hrdata_nxt = 32'h0000_0000;
    if (ap_valid && !hwrite) begin
      unique case (haddr[7:0])
        `PDC_OFS_CPTR0: hrdata_nxt[7:0] = cptr_r[0];
        `PDC_OFS_APTR0: hrdata_nxt[7:0] = aptr_r[0];
        `PDC_OFS_CPTR1: hrdata_nxt[7:0] = cptr_r[1];
        `PDC_OFS_APTR1: hrdata_nxt[7:0] = aptr_r[1];
        `PDC_OFS_CTRL: hrdata_nxt[7:0] = {2'b00, pend_r, mask_r, imsk_r, prio_r};
        `PDC_OFS_SWAP: hrdata_nxt[7:0] = {4'h0, dma_busy, eob_r, tsel_r, swap_en_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bw_r <= 1'b0;
      wa_r <= `PDC_RST_BYTE;
      hrdata_r <= 32'h0000_0000;
    end else begin
      bw_r <= bw_nxt;
      wa_r <= wa_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // descriptor slots of the running transfer
  assign cpe = {dcp_r[7:1], 1'b0}; // [R2] [R4]
  assign cpo = {dcp_r[7:1], 1'b1};
  assign ape = {dap_r[7:1], 1'b0};
  assign apo = {dap_r[7:1], 1'b1};
  assign adr_inc = adr_r + 16'h0001; // [R6]
  assign cnt_dec = cnt_r - 16'h0001;

  assign tick = (samp_r == `PDC_SAMPLE_LAST); // [R17]
  // lower number is higher priority
  assign dma_ok = pend_r & mask_r & (prio_r <= core_in.current_priority_level) & ~core_in.top_isr; // [R10] [R12] [R16] [R24]
  assign irq_cond = imsk_r & (eob_r | (pend_r & ~mask_r)); // [R23]
  assign irq_ok = irq_cond & (prio_r < core_in.current_priority_level); // [R11] [R12]
  assign last_step = rfm_r ? (step_r == `PDC_RF_LAST) : (step_r == `PDC_MEM_LAST); // [R18] [R19]
  // count 0 in memory mode wraps, giving the full 65536 transfers
  assign zero = rfm_r ? (cnt_r[7:0] == 8'h01) : (cnt_r == 16'h0001); // [R1]
  assign block_end = dma_busy & last_step & zero;
  assign stall = dma_busy & ~rfm_r & (step_r == `PDC_M_MOVE) & ~mem_ready; // [R19]

  // register-file and memory strobes follow the step counter
  always_comb begin
    rf_req = '0;
    mem_req = '0;
    if (dma_busy && rfm_r) begin
      case (step_r)
        `PDC_RF_RDA: begin rf_req.addr = cpe; rf_req.re = 1'b1; end
        `PDC_RF_RDC: begin rf_req.addr = cpo; rf_req.re = 1'b1; end
        `PDC_RF_MOVE: begin // [R9]
          rf_req.addr = adr_r[7:0];
          rf_req.we = periph_to_core;
          rf_req.re = ~periph_to_core;
          rf_req.wdata = periph_rdata;
        end
        `PDC_RF_WRA: begin
          rf_req.addr = cpe;
          rf_req.we = 1'b1;
          rf_req.wdata = adr_inc[7:0];
        end
        `PDC_RF_WRC: begin
          rf_req.addr = cpo;
          rf_req.we = 1'b1;
          rf_req.wdata = cnt_dec[7:0];
        end
        default: rf_req = '0;
      endcase
    end else if (dma_busy) begin
      case (step_r)
        `PDC_M_RDCH: begin rf_req.addr = cpe; rf_req.re = 1'b1; end
        `PDC_M_RDCL: begin rf_req.addr = cpo; rf_req.re = 1'b1; end
        `PDC_M_RDAH: begin rf_req.addr = ape; rf_req.re = 1'b1; end
        `PDC_M_RDAL: begin rf_req.addr = apo; rf_req.re = 1'b1; end
        `PDC_M_MOVE: begin
          mem_req.req = 1'b1;
          mem_req.we = periph_to_core;
          mem_req.seg_sel = dap_r[0]; // [R5]
          mem_req.addr = adr_r;
          mem_req.wdata = periph_rdata;
        end
        `PDC_M_WRAH: begin rf_req.addr = ape; rf_req.we = 1'b1; rf_req.wdata = adr_inc[15:8]; end
        `PDC_M_WRAL: begin rf_req.addr = apo; rf_req.we = 1'b1; rf_req.wdata = adr_inc[7:0]; end
        `PDC_M_WRCH: begin rf_req.addr = cpe; rf_req.we = 1'b1; rf_req.wdata = cnt_dec[15:8]; end
        `PDC_M_WRCL: begin rf_req.addr = cpo; rf_req.we = 1'b1; rf_req.wdata = cnt_dec[7:0]; end
        default: rf_req = '0;
      endcase
    end
  end

  // channel next state
  always_comb begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    mask_nxt = mask_r;
    imsk_nxt = imsk_r;
    prio_nxt = prio_r;
    cptr_nxt = cptr_r;
    aptr_nxt = aptr_r;
    swap_en_nxt = swap_en_r;
    tsel_nxt = tsel_r;
    eob_nxt = eob_r;
    irq_req_nxt = irq_req_r;
    samp_nxt = tick ? 3'h0 : samp_r + 3'h1; // [R17]
    step_nxt = step_r;
    rfm_nxt = rfm_r;
    dcp_nxt = dcp_r;
    dap_nxt = dap_r;
    cnt_nxt = cnt_r;
    adr_nxt = adr_r;
    pwd_nxt = pwd_r;
    pwr_nxt = 1'b0;
    prd_nxt = 1'b0;
    if (bw_r) begin
      unique case (wa_r)
        `PDC_OFS_CPTR0: cptr_nxt[0] = wd;
        `PDC_OFS_APTR0: aptr_nxt[0] = wd;
        `PDC_OFS_CPTR1: cptr_nxt[1] = wd;
        `PDC_OFS_APTR1: aptr_nxt[1] = wd;
        `PDC_OFS_CTRL: begin
          pend_nxt = wd[`PDC_CTL_PEND]; // [R22]
          mask_nxt = wd[`PDC_CTL_MASK];
          imsk_nxt = wd[`PDC_CTL_IMSK];
          prio_nxt = wd[2:0];
        end
        `PDC_OFS_SWAP: swap_en_nxt = wd[`PDC_SWP_EN];
        default: ;
      endcase
    end
    if (core_in.irq_ack) begin
      irq_req_nxt = 1'b0;
      eob_nxt = 1'b0;
      if (!mask_r) pend_nxt = 1'b0; // [R22]
    end
    unique case (state_r)
      ST_IDLE: begin
        if (tick && dma_ok) begin
          state_nxt = ST_ARMED; // [R11]
        end
        // transfer wins a tie; no irq raised while one is granted
        if (tick && irq_ok && !dma_ok) begin
          irq_req_nxt = 1'b1; // [R13] [R14]
        end
      end
      ST_ARMED: begin
        // grant lands at the instruction boundary
        if (core_in.instr_end) begin // [R12]
          state_nxt = ST_RUN;
          step_nxt = 5'h00;
          pend_nxt = 1'b0; // [R22]
          rfm_nxt = cptr_r[tsel_r][0]; // [R3]
          dcp_nxt = cptr_r[tsel_r]; // [R20] [R25]
          dap_nxt = aptr_r[tsel_r];
        end
      end
      ST_RUN: begin
        if (rfm_r) begin
          case (step_r)
            `PDC_RF_RDA: adr_nxt = {8'h00, rf_rdata};
            `PDC_RF_RDC: cnt_nxt = {8'h00, rf_rdata};
            `PDC_RF_MOVE: begin // [R6] [R9]
              prd_nxt = periph_to_core;
              pwr_nxt = ~periph_to_core;
              if (!periph_to_core) pwd_nxt = rf_rdata;
            end
            default: ;
          endcase
        end else begin
          case (step_r)
            `PDC_M_RDCH: cnt_nxt[15:8] = rf_rdata; // [R4]
            `PDC_M_RDCL: cnt_nxt[7:0] = rf_rdata;
            `PDC_M_RDAH: adr_nxt[15:8] = rf_rdata;
            `PDC_M_RDAL: adr_nxt[7:0] = rf_rdata;
            `PDC_M_MOVE: begin
              if (mem_ready) begin
                prd_nxt = periph_to_core;
                pwr_nxt = ~periph_to_core;
                if (!periph_to_core) pwd_nxt = mem_rdata;
              end
            end
            default: ;
          endcase
        end
        if (!stall) step_nxt = step_r + 5'h01;
        if (last_step) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (block_end) begin
      eob_nxt = 1'b1; // [R15]
      if (swap_en_r) begin
        tsel_nxt = ~tsel_r; // [R20] [R21] [R25]
      end else begin
        mask_nxt = 1'b0; // [R15]
      end
    end
    // a trigger in the clearing cycle is kept
    if (trigger) pend_nxt = 1'b1; // [R22]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      pend_r <= 1'b0;
      mask_r <= 1'b0;
      imsk_r <= 1'b0;
      prio_r <= `PDC_RST_PRIO;
      cptr_r <= '0;
      aptr_r <= '0;
      swap_en_r <= 1'b0;
      tsel_r <= 1'b0;
      eob_r <= 1'b0;
      irq_req_r <= 1'b0;
      samp_r <= 3'h0;
      step_r <= 5'h00;
      rfm_r <= 1'b0;
      dcp_r <= `PDC_RST_BYTE;
      dap_r <= `PDC_RST_BYTE;
      cnt_r <= 16'h0000;
      adr_r <= 16'h0000;
      pwd_r <= `PDC_RST_BYTE;
      pwr_r <= 1'b0;
      prd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      mask_r <= mask_nxt;
      imsk_r <= imsk_nxt;
      prio_r <= prio_nxt;
      cptr_r <= cptr_nxt;
      aptr_r <= aptr_nxt;
      swap_en_r <= swap_en_nxt;
      tsel_r <= tsel_nxt;
      eob_r <= eob_nxt;
      irq_req_r <= irq_req_nxt;
      samp_r <= samp_nxt;
      step_r <= step_nxt;
      rfm_r <= rfm_nxt;
      dcp_r <= dcp_nxt;
      dap_r <= dap_nxt;
      cnt_r <= cnt_nxt;
      adr_r <= adr_nxt;
      pwd_r <= pwd_nxt;
      pwr_r <= pwr_nxt;
      prd_r <= prd_nxt;
    end
  end

  // helper: length of the current busy run
  logic [7:0] run_len_r, run_len_nxt;
  always_comb begin
    run_len_nxt = dma_busy ? run_len_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_len_r <= 8'h00;
    else run_len_r <= run_len_nxt;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_rf_cost_len: assert property ( // [R18]
    $rose(dma_busy) && rfm_r |-> dma_busy [*8] ##1 !dma_busy)
    else $error("register-file transfer not eight cycles");
  chk_mem_cost_min: assert property ( // [R19]
    $fell(dma_busy) && $past(rfm_r) == 1'b0 |-> run_len_r >= 8'h10)
    else $error("memory transfer shorter than sixteen cycles");
  chk_sample_period: assert property ( // [R17]
    tick |=> !tick [*4] ##1 tick)
    else $error("request sampling not every five cycles");
  chk_pend_ack_clr: assert property ( // [R22]
    $rose(dma_busy) |-> !pend_r || $past(trigger))
    else $error("pending not cleared on acknowledge");
  chk_mask_block_end: assert property ( // [R15]
    block_end && !swap_en_r |=> !mask_r && eob_r)
    else $error("block end did not clear mask and flag irq");
  chk_swap_table: assert property ( // [R21]
    block_end && swap_en_r |=> mask_r && eob_r && (tsel_r != $past(tsel_r)))
    else $error("swap block end did not keep mask and switch table");
  chk_grant_prio: assert property ( // [R12]
    state_r == ST_ARMED && $past(state_r) == ST_IDLE |-> $past(dma_ok) && $past(tick))
    else $error("transfer granted without priority or sample");
  chk_irq_after_dma: assert property ( // [R13]
    $rose(irq_req_r) |-> $past(irq_ok) && !$past(dma_ok) && $past(state_r) == ST_IDLE)
    else $error("interrupt raised over an equal transfer request");

endmodule : pdc_channel

// ===== dv/pdc_far_model.sv
// register file and byte memory seen by the dma channel
module pdc_far_model
  import pdc_pkg::*;
(
  input wire logic hclk,
  input wire pdc_pkg::pdc_rf_req_t rf_req,
  output logic [7:0] rf_rdata,
  input wire pdc_pkg::pdc_mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  output logic mem_ready,
  input wire logic [3:0] waits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rf_mem [256];
  logic [7:0] mem [256];
  logic [3:0] wcnt;
  logic [15:0] last_addr;
  logic last_seg;
  initial wcnt = 4'h0;
  // lines not being read show inverted data, never a stale copy
  assign rf_rdata = rf_req.re ? rf_mem[rf_req.addr] : ~rf_mem[rf_req.addr];
  assign mem_ready = mem_req.req && (wcnt == waits);
  assign mem_rdata = mem_ready ? mem[mem_req.addr[7:0]] : ~mem[mem_req.addr[7:0]];
  always @(posedge hclk) begin
    if (rf_req.we) rf_mem[rf_req.addr] <= rf_req.wdata;
    if (mem_req.req) last_addr <= mem_req.addr;
    if (mem_req.req) last_seg <= mem_req.seg_sel;
    if (mem_ready && mem_req.we) mem[mem_req.addr[7:0]] <= mem_req.wdata;
    wcnt <= (mem_ready || !mem_req.req) ? 4'h0 : wcnt + 4'h1;
  end
endmodule : pdc_far_model

// ===== dv/tb.sv
// self-checking bench for the dma channel
module tb;
  import pdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, trigger, p2c, ie, ie_en, top, ack;
  logic hreadyout, hresp, dma_busy, irq_req, pwr, prd, mem_ready;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] current_priority_level, irq_level;
  logic [7:0] pdat, pwd, pw_got, rf_rdata, mem_rdata;
  logic [3:0] waits;
  pdc_rf_req_t rf_req;
  pdc_mem_req_t mem_req;
  pdc_core_in_t core;
  int n_errors, checks_done, n_rd;
  assign core = '{current_priority_level, top, ie, ack};
  pdc_channel pdc_channel_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_in(core),
    .dma_busy(dma_busy), .irq_req(irq_req), .irq_level(irq_level), .trigger(trigger),
    .periph_to_core(p2c), .periph_rdata(pdat), .periph_wdata(pwd), .periph_wr(pwr),
    .periph_rd(prd), .rf_req(rf_req), .rf_rdata(rf_rdata), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready));
  pdc_far_model pdc_far_model_i (.hclk(hclk), .rf_req(rf_req), .rf_rdata(rf_rdata),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .waits(waits));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // instruction boundary every other cycle while enabled
  always @(posedge hclk) ie <= ie_en & ~ie;
  always @(posedge hclk) if (pwr === 1'b1) pw_got <= pwd;
  // peripheral reads seen so far, one per transfer towards the core
  always @(posedge hclk) if (prd === 1'b1) n_rd++;
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_len(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected at %0t: %0d cycles, want %0d", $time, got, exp);
    end
  endtask : cmp_len
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, d, 1'b1);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 8'h00, 1'b0);
    cmp_val(q, exp);
  endtask : rdc
  // outputs read at the edge still hold the value of the cycle just ended
  task automatic tick();
    @(posedge hclk);
  endtask : tick
  task automatic pulse_ack();
    @(posedge hclk);
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    tick();
  endtask : pulse_ack
  // waits are bounded so a channel that never starts shows as length 0
  task automatic xfer(input int exp_len);
    int n;
    n = 0;
    @(posedge hclk);
    trigger <= 1'b1;
    @(posedge hclk);
    trigger <= 1'b0;
    ie_en <= 1'b1;
    while (dma_busy !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    n = 0;
    while (dma_busy === 1'b1 && n < 60) begin
      tick();
      n++;
    end
    ie_en <= 1'b0;
    cmp_len(n, exp_len);
    repeat (3) @(posedge hclk);
  endtask : xfer
  task automatic idle_chk();
    int n;
    n = 0;
    ie_en <= 1'b1;
    repeat (20) begin
      tick();
      if (dma_busy === 1'b1) n++;
    end
    ie_en <= 1'b0;
    cmp_len(n, 0);
  endtask : idle_chk
  task automatic t_reset();
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h20};
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    rdc(8'h08, 32'h07);
    cmp_val(irq_level, 3'h7);
    cmp_val(hresp, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_swap();
    int n;
    pdc_far_model_i.rf_mem[8'h10] = 8'h40;
    pdc_far_model_i.rf_mem[8'h11] = 8'h01;
    pdc_far_model_i.rf_mem[8'h14] = 8'h60;
    pdc_far_model_i.rf_mem[8'h15] = 8'h01;
    current_priority_level <= 3'h3;
    p2c <= 1'b1;
    pdat <= 8'hA5;
    wr(8'h00, 8'h11);
    wr(8'h0C, 8'h15);
    wr(8'h14, 8'h01);
    wr(8'h08, 8'h1B);
    xfer(8);
    cmp_val(pdc_far_model_i.rf_mem[8'h40], 8'hA5);
    cmp_val(pdc_far_model_i.rf_mem[8'h10], 8'h41);
    cmp_val(pdc_far_model_i.rf_mem[8'h11], 8'h00);
    rdc(8'h14, 32'h07);
    rdc(8'h08, 32'h1B);
    repeat (12) tick();
    cmp_val(irq_req, 1'b0);
    current_priority_level <= 3'h4;
    n = 0;
    while (irq_req !== 1'b1 && n < 12) begin
      tick();
      n++;
    end
    cmp_val(irq_req, 1'b1);
    cmp_val(irq_level, 3'h3);
    pulse_ack();
    cmp_val(irq_req, 1'b0);
    pdat <= 8'h3C;
    xfer(8);
    cmp_val(pdc_far_model_i.rf_mem[8'h60], 8'h3C);
    cmp_val(pdc_far_model_i.rf_mem[8'h14], 8'h61);
    rdc(8'h14, 32'h05);
    cmp_len(n_rd, 2);
    pulse_ack();
    $display("test swap done");
  endtask : t_swap
  task automatic t_block();
    pdc_far_model_i.rf_mem[8'h10] = 8'h50;
    pdc_far_model_i.rf_mem[8'h11] = 8'h02;
    current_priority_level <= 3'h3;
    pdat <= 8'h77;
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h11);
    wr(8'h08, 8'h35);
    idle_chk();
    top <= 1'b1;
    wr(8'h08, 8'h33);
    idle_chk();
    top <= 1'b0;
    xfer(8);
    rdc(8'h08, 32'h13);
    cmp_val(pdc_far_model_i.rf_mem[8'h50], 8'h77);
    cmp_val(pdc_far_model_i.rf_mem[8'h11], 8'h01);
    cmp_len(n_rd, 3);
    $display("test block done");
  endtask : t_block
  task automatic t_mem();
    pdc_far_model_i.rf_mem[8'h20] = 8'h00;
    pdc_far_model_i.rf_mem[8'h21] = 8'h01;
    pdc_far_model_i.rf_mem[8'h30] = 8'h12;
    pdc_far_model_i.rf_mem[8'h31] = 8'h34;
    pdc_far_model_i.mem[8'h34] = 8'h5A;
    waits <= 4'h3;
    p2c <= 1'b0;
    wr(8'h00, 8'h20);
    wr(8'h04, 8'h31);
    wr(8'h08, 8'h12);
    xfer(19);
    cmp_val(pw_got, 8'h5A);
    cmp_val(pdc_far_model_i.last_addr, 16'h1234);
    cmp_val(pdc_far_model_i.last_seg, 1'b1);
    cmp_val(pdc_far_model_i.rf_mem[8'h31], 8'h35);
    cmp_val(pdc_far_model_i.rf_mem[8'h21], 8'h00);
    rdc(8'h08, 32'h02);
    cmp_len(n_rd, 3);
    // pending with the transfer mask off only asks for the interrupt
    wr(8'h08, 8'h2A);
    idle_chk();
    cmp_val(irq_req, 1'b1);
    pulse_ack();
    rdc(8'h08, 32'h0A);
    $display("test memory done");
  endtask : t_mem
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    trigger = 1'b0;
    p2c = 1'b0;
    ie = 1'b0;
    ie_en = 1'b0;
    top = 1'b0;
    ack = 1'b0;
    current_priority_level = 3'h0;
    pdat = 8'h00;
    waits = 4'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_swap();
    t_block();
    t_mem();
    final_report();
  end
endmodule : tb
